// ### fsk_consts.svh
// Constants for the flash security and key verify block.
// Assumes inclusion by bare name from the design files and the bench.
`ifndef FSK_CONSTS_SVH
`define FSK_CONSTS_SVH
// Register byte offsets on the APB bus.
`define FSK_OFF_CTRL     12'h000
`define FSK_OFF_STAT     12'h004
`define FSK_OFF_IRQ      12'h008
`define FSK_OFF_MASK     12'h00C
`define FSK_OFF_CCOBIX   12'h010
`define FSK_OFF_CCOB     12'h014
`define FSK_OFF_SEC      12'h018
`define FSK_OFF_PWR      12'h01C
// Global addresses of the configuration field.
`define FSK_ADDR_KEY0    18'h3FF00
`define FSK_ADDR_SECBYTE 18'h3FF0F
// Command codes.
`define FSK_CMD_ERSVSEC  8'h03
`define FSK_CMD_VFYKEY   8'h0C
// Security field encodings.
`define FSK_SEC_UNSEC    2'h2
`define FSK_KEYEN_ON     2'h2
// Forbidden key patterns.
`define FSK_KEY_ZERO     16'h0000
`define FSK_KEY_ONES     16'hFFFF
// Status bit positions.
`define FSK_ST_COMMAND_COMPLETE_FLAG      0
`define FSK_ST_ACCESS_ERROR_FLAG    1
`define FSK_ST_MG0       2
`define FSK_ST_MG1       3
`define FSK_ST_SECURED   4
`define FSK_ST_KEYLOCK   5
`define FSK_ST_STOPACK   6
`define FSK_ST_RDINV     7
// Interrupt event bit positions.
`define FSK_EV_DONE      0
`define FSK_EV_ERR       1
`endif

// ### fsk_pkg.sv
// Types for the flash security and key verify block.
// Assumes fsk_consts.svh holds the numeric constants.
package fsk_pkg;
  // Sequencer states.
  typedef enum logic [2:0] {
    FSK_BOOT_RD, FSK_BOOT_LD, FSK_IDLE, FSK_RUN, FSK_DONE
  } fsk_state_t;
endpackage

// ### fsk_nvm_rd.sv
// Read port sequencer: fetches one word of flash through a memory port.
// Assumes a read memory answering one cycle after the request.
`timescale 1ns/10ps
`include "fsk_consts.svh"
module fsk_nvm_rd (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Request side.
  input  wire logic        req,
  input  wire logic [17:0] addr,
  output logic             ack,
  output logic [15:0]      data,
  // Memory side.
  output logic             mem_rd,
  output logic [17:0]      mem_addr,
  input  wire logic [15:0] mem_rdata
);
  // Pending marks that a read went out last cycle.
  logic pend_r;

  // Memory request is combinational; data is caught in flops.
  // A new request waits until the last answer has been taken, so that
  // the requester has moved its address on before the next fetch.
  assign mem_rd   = req & ~pend_r & ~ack;
  assign mem_addr = addr;

  // The word arrives the cycle after the request.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 1'b0;
      ack    <= 1'b0;
      data   <= 16'h0000;
    end else begin
      pend_r <= mem_rd;
      ack    <= pend_r;
      if (pend_r) begin
        data <= mem_rdata;
      end
    end
  end
endmodule

// ### fsk_ctrl.sv
// Flash security loader, backdoor key verifier and command sequencer.
// Assumes an APB master on pclk and a flash read port answering in a cycle.
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "fsk_consts.svh"
// Operation
// - Keep running in wait; completion irq wakes.
// - Stop request waits for running command end.
// - Load security register from byte at reset.
// - New security byte applies after next reset.
// - Four stored key words are references.
// - Key verify only when key enable on.
// - All keys match: chip becomes unsecured.
// - Keys 0x0000 or 0xFFFF never match.
// - Flash reads invalid during key verify.
// - Count at index two; launch by clear.
// - Misaligned start address sets access error.
// - Wrong key locks verify until reset.
module fsk_ctrl (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Flash read port.
  output logic             mem_rd,
  output logic [17:0]      mem_addr,
  input  wire logic [15:0] mem_rdata,
  // Power handshake.
  input  wire logic        stop_req,
  output logic             stop_ack,
  output logic             read_invalid,
  // Interrupt.
  output logic             irq
);
  // Sequencer and command storage.
  fsk_pkg::fsk_state_t state_r;
  logic [15:0] ccob_r [0:5];     // Command object words.
  logic [2:0]  ccobix_r;         // Command object index.
  logic [7:0]  sec_r;            // Security register.
  logic        command_complete_flag_r;           // Command complete flag.
  logic        access_error_flag_r;         // Access error flag.
  logic [1:0]  memory_controller_status_bits_r;         // Memory controller status.
  logic        keylock_r;        // Key verify blocked.
  logic        keyok_r;          // Running compare result.
  logic [2:0]  step_r;           // Word counter in a command.
  logic [15:0] cnt_r;            // Phrases left to check.
  logic [17:0] ptr_r;            // Current flash address.
  logic        vfykey_r;         // Key verify in progress.
  logic [1:0]  irqst_r;          // Sticky interrupt status.
  logic [1:0]  mask_r;           // Interrupt mask.
  // Read engine hookup.
  logic        rd_req;
  logic        rd_ack;
  logic [15:0] rd_data;
  logic [31:0] rd_mux;           // Read data chosen by address.

  fsk_nvm_rd u_rd (
    .pclk      (pclk),
    .presetn   (presetn),
    .req       (rd_req),
    .addr      (ptr_r),
    .ack       (rd_ack),
    .data      (rd_data),
    .mem_rd    (mem_rd),
    .mem_addr  (mem_addr),
    .mem_rdata (mem_rdata)
  );

  // A key word is usable only when not all zeros or all ones.
  function automatic logic key_valid(input logic [15:0] k);
    key_valid = (k != `FSK_KEY_ZERO) && (k != `FSK_KEY_ONES);
  endfunction

  // Bus decode; every access completes in its first access cycle.
  wire acc      = psel & penable;
  wire wr       = acc & pwrite;
  wire wr_ctrl  = wr & (paddr == `FSK_OFF_CTRL);
  wire wr_irq   = wr & (paddr == `FSK_OFF_IRQ);
  wire wr_mask  = wr & (paddr == `FSK_OFF_MASK);
  wire wr_ix    = wr & (paddr == `FSK_OFF_CCOBIX);
  wire wr_ccob  = wr & (paddr == `FSK_OFF_CCOB);
  wire mapped   = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
  wire idle     = (state_r == fsk_pkg::FSK_IDLE);
  // Writing a one to the busy bit while idle and complete launches.
  wire launch   = wr_ctrl & pwdata[0] & idle & command_complete_flag_r;
  wire [7:0] cmd = ccob_r[0][15:8];
  wire is_ersv  = (cmd == `FSK_CMD_ERSVSEC);
  wire is_vfy   = (cmd == `FSK_CMD_VFYKEY);
  wire keyen_on = (sec_r[7:6] == `FSK_KEYEN_ON);
  // Launch checks: index, alignment, key enable and lock.
  wire ersv_bad = (ccobix_r != 3'h2) || (ccob_r[1][2:0] != 3'h0);
  wire vfy_bad  = (ccobix_r != 3'h4) || !keyen_on || keylock_r;
  wire rejected = launch & (is_ersv ? ersv_bad
                          : (is_vfy ? vfy_bad : 1'b1));
  wire started  = launch & ~rejected;
  wire done_ev  = (state_r == fsk_pkg::FSK_DONE);
  // Blank check result and key compare for the current word.
  wire blank_ok = (rd_data == 16'hFFFF);
  wire key_hit  = (rd_data == ccob_r[step_r + 3'h1]) &&
                  key_valid(rd_data);

  assign rd_req = (state_r == fsk_pkg::FSK_BOOT_RD) ||
                  (state_r == fsk_pkg::FSK_RUN);
  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign irq     = |(irqst_r & mask_r);
  // Stop granted only while no command is running.
  assign stop_ack = stop_req & command_complete_flag_r & idle;
  assign read_invalid = vfykey_r;

  // Read data mux, chosen by the address of the pending transfer.
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `FSK_OFF_CTRL:   rd_mux = {31'h0, ~command_complete_flag_r};
      `FSK_OFF_STAT:   rd_mux = {24'h0, vfykey_r, stop_ack, keylock_r,
                                 (sec_r[1:0] != `FSK_SEC_UNSEC),
                                 memory_controller_status_bits_r, access_error_flag_r, command_complete_flag_r};
      `FSK_OFF_IRQ:    rd_mux = {30'h0, irqst_r};
      `FSK_OFF_MASK:   rd_mux = {30'h0, mask_r};
      `FSK_OFF_CCOBIX: rd_mux = {29'h0, ccobix_r};
      `FSK_OFF_CCOB:   rd_mux = (ccobix_r < 3'h6) ?
                                {16'h0, ccob_r[ccobix_r]} : 32'h0;
      `FSK_OFF_SEC:    rd_mux = {24'h0, sec_r};
      default:         rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data is caught in the setup cycle so that it leaves a flop;
  // the access cycle then returns it with no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= rd_mux;
    end
  end

  // Command object array; writes beyond index five are dropped.
  always_ff @(posedge pclk) begin
    if (wr_ccob && idle && ccobix_r < 3'h6) begin
      ccob_r[ccobix_r] <= pwdata[15:0];
    end
  end

  // Sequencer. After reset the security byte is fetched once; software
  // programming of that byte reaches this register only via a new reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r   <= fsk_pkg::FSK_BOOT_RD;
      ptr_r     <= `FSK_ADDR_SECBYTE;
      sec_r     <= 8'h00;
      command_complete_flag_r    <= 1'b0;
      access_error_flag_r  <= 1'b0;
      memory_controller_status_bits_r  <= 2'h0;
      keylock_r <= 1'b0;
      keyok_r   <= 1'b0;
      step_r    <= 3'h0;
      cnt_r     <= 16'h0000;
      vfykey_r  <= 1'b0;
      ccobix_r  <= 3'h0;
    end else begin
      if (wr_ix) begin
        ccobix_r <= pwdata[2:0];
      end
      case (state_r)
        fsk_pkg::FSK_BOOT_RD: begin
          if (rd_ack) begin
            // Odd address holds the byte in the low lane.
            sec_r   <= rd_data[7:0];
            state_r <= fsk_pkg::FSK_BOOT_LD;
          end
        end
        fsk_pkg::FSK_BOOT_LD: begin
          command_complete_flag_r  <= 1'b1;
          state_r <= fsk_pkg::FSK_IDLE;
        end
        fsk_pkg::FSK_IDLE: begin
          if (launch) begin
            command_complete_flag_r   <= 1'b0;
            access_error_flag_r <= rejected;
            memory_controller_status_bits_r <= 2'h0;
            step_r   <= 3'h0;
            keyok_r  <= 1'b1;
            if (rejected) begin
              state_r <= fsk_pkg::FSK_DONE;
            end else if (is_vfy) begin
              vfykey_r <= 1'b1;
              ptr_r    <= `FSK_ADDR_KEY0;
              state_r  <= fsk_pkg::FSK_RUN;
            end else begin
              ptr_r   <= {ccob_r[0][1:0], ccob_r[1]};
              cnt_r   <= ccob_r[2];
              state_r <= (ccob_r[2] == 16'h0000) ?
                         fsk_pkg::FSK_DONE : fsk_pkg::FSK_RUN;
            end
          end
        end
        fsk_pkg::FSK_RUN: begin
          if (rd_ack) begin
            ptr_r <= ptr_r + 18'h00002;
            if (vfykey_r) begin
              // Compare stored word against candidate word.
              keyok_r <= keyok_r & key_hit;
              step_r  <= step_r + 3'h1;
              if (step_r == 3'h3) begin
                state_r <= fsk_pkg::FSK_DONE;
              end
            end else begin
              // A word that is not erased ends the check at once.
              if (!blank_ok) begin
                memory_controller_status_bits_r <= 2'h3;
                state_r  <= fsk_pkg::FSK_DONE;
              end
              // Four words make one phrase.
              step_r <= step_r + 3'h1;
              if (step_r == 3'h3) begin
                cnt_r  <= cnt_r - 16'h0001;
                step_r <= 3'h0;
                if (cnt_r == 16'h0001 || !blank_ok) begin
                  state_r <= fsk_pkg::FSK_DONE;
                end
              end
            end
          end
        end
        fsk_pkg::FSK_DONE: begin
          if (vfykey_r) begin
            if (keyok_r) begin
              sec_r[1:0] <= `FSK_SEC_UNSEC;
            end else begin
              keylock_r <= 1'b1;
              access_error_flag_r  <= 1'b1;
            end
          end
          vfykey_r <= 1'b0;
          command_complete_flag_r   <= 1'b1;
          state_r  <= fsk_pkg::FSK_IDLE;
        end
        default: state_r <= fsk_pkg::FSK_IDLE;
      endcase
    end
  end

  // Sticky interrupt status; set beats a write-one clear.
  // Completion interrupt also serves as the wake from wait mode.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irqst_r <= 2'h0;
      mask_r  <= 2'h0;
    end else begin
      if (wr_mask) begin
        mask_r <= pwdata[1:0];
      end
      irqst_r[`FSK_EV_DONE] <= done_ev |
        (irqst_r[`FSK_EV_DONE] & ~(wr_irq & pwdata[`FSK_EV_DONE]));
      // A failed key compare raises its error flag in the same cycle.
      irqst_r[`FSK_EV_ERR] <= (done_ev & (access_error_flag_r | (|memory_controller_status_bits_r) |
                               (vfykey_r & ~keyok_r))) |
        (irqst_r[`FSK_EV_ERR] & ~(wr_irq & pwdata[`FSK_EV_ERR]));
    end
  end
endmodule

// ### fsk_ctrl_asserts.sv
// Checker on the ports of the flash security block.
// Assumes one clock domain and a bind onto fsk_ctrl.
`timescale 1ns/10ps
module fsk_ctrl_asserts (
  // Watched ports.
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [11:0] paddr,
  input wire logic        pslverr,
  input wire logic        mem_rd,
  input wire logic [17:0] mem_addr,
  input wire logic        stop_req,
  input wire logic        stop_ack,
  input wire logic        read_invalid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // The security byte is fetched soon after reset is released.
  sequence s_sec_fetch;
    ##[0:3] (mem_rd && mem_addr == 18'h3FF0F);
  endsequence
  // A verify fetches the stored key words.
  sequence s_key_fetch;
    ##[0:6] (mem_rd && mem_addr[17:3] == 15'h7FE0);
  endsequence
  property p_boot; $rose(presetn) |-> s_sec_fetch; endproperty
  property p_stop_idle; stop_ack |-> stop_req && !read_invalid; endproperty
  property p_stop_drop; $fell(stop_req) |-> !stop_ack; endproperty
  property p_stop_quiet; stop_ack |-> !mem_rd; endproperty
  property p_rdinv_len; $rose(read_invalid) |-> ##[1:40] !read_invalid;
  endproperty
  property p_rdinv_keys; $rose(read_invalid) |-> s_key_fetch; endproperty
  property p_unmapped; psel && penable && paddr > 12'h01C |-> pslverr;
  endproperty
  property p_mapped;
    psel && penable && paddr <= 12'h01C && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_boot: assert property (p_boot)
    else $error("security byte not fetched after reset");
  a_stop_idle: assert property (p_stop_idle)
    else $error("stop granted while busy");
  a_stop_drop: assert property (p_stop_drop)
    else $error("stop grant outlived request");
  a_stop_quiet: assert property (p_stop_quiet)
    else $error("flash read while stop granted");
  a_rdinv_len: assert property (p_rdinv_len)
    else $error("read invalid window too long");
  a_rdinv_keys: assert property (p_rdinv_keys)
    else $error("verify did not fetch stored keys");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not refused");
  a_mapped: assert property (p_mapped)
    else $error("mapped access refused");
endmodule

// ### fsk_flash_model.sv
// Flash array model behind the read port of the block.
// Assumes a request on mem_rd is answered at the next clock edge.
`timescale 1ns/10ps
module fsk_flash_model #(
  parameter logic [7:0] SEC_BYTE = 8'h80 // Key access on, chip secured.
) (
  // Clock.
  input  wire logic        pclk,
  // Bench control: the last stored key reads as an erased word.
  input  wire logic        blank_keys,
  // Read port.
  input  wire logic        mem_rd,
  input  wire logic [17:0] mem_addr,
  output logic      [15:0] mem_rdata
);
  logic [17:0] wa; // Word address of the request.
  assign wa = {mem_addr[17:1], 1'b0};
  // Stale data is scrambled so an early or late sample never passes.
  always @(posedge pclk) begin
    if (!mem_rd) mem_rdata <= ~mem_rdata;
    else case (wa)
      18'h3FF00: mem_rdata <= 16'h1111;
      18'h3FF02: mem_rdata <= 16'h2222;
      18'h3FF04: mem_rdata <= 16'h3333;
      18'h3FF06: mem_rdata <= blank_keys ? 16'hFFFF : 16'h4444;
      // The security byte is fixed; the bench never reprograms it.
      18'h3FF0E: mem_rdata <= {8'hFF, SEC_BYTE};
      18'h00100: mem_rdata <= 16'h1234; // A programmed word.
      default:   mem_rdata <= 16'hFFFF;
    endcase
  end
  initial mem_rdata = 16'h5A5A;
endmodule

// ### test_fsk_ctrl.sv
// Self-checking bench for fsk_ctrl with a flash model on its read port.
// Assumes APB answers without wait states and keys 1111..4444 stored.
`timescale 1ns/10ps
`include "fsk_consts.svh"
module test_fsk_ctrl;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        stop_req = 0, pready, pslverr, mem_rd, stop_ack, rdinv;
  logic        irq, slv, seen;
  logic        blank_keys = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [17:0] mem_addr;
  logic [15:0] mem_rdata;
  int          num_errors = 0, num_checks = 0;
  always #4 pclk = ~pclk;
  fsk_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .mem_rd(mem_rd),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata), .stop_req(stop_req),
    .stop_ack(stop_ack), .read_invalid(rdinv), .irq(irq));
  fsk_flash_model mem (.pclk(pclk), .blank_keys(blank_keys),
    .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_rdata(mem_rdata));
  task end_sim;
    $display("Checks %0d, errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One transfer; the request holds until pready is sampled high.
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      $display("Error at %0t: bus timeout", $time);
      num_errors++; end_sim;
    end
    rd = prdata; slv = pslverr; psel <= 0; penable <= 0;
  endtask
  // Polls completion; notes whether the verify window was seen.
  task wait_done;
    for (int n = 0; n < 100; n++) begin
      apb(0, `FSK_OFF_STAT, 0);
      if (rdinv === 1'b1) seen = 1;
      if (rd[0] === 1'b1) return;
    end
    $display("Error at %0t: command timeout", $time);
    num_errors++; end_sim;
  endtask
  task cmd(input int n, input logic [15:0] w [5]);
    for (int i = 0; i < n; i++) begin
      apb(1, `FSK_OFF_CCOBIX, 32'(i));
      apb(1, `FSK_OFF_CCOB, {16'h0, w[i]});
    end
    apb(1, `FSK_OFF_CTRL, 1);
    wait_done;
  endtask
  task do_reset;
    presetn <= 0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    wait_done;
  endtask
  // Wrong key locks verify, then a reset lifts the lock.
  task t_keys;
    apb(0, `FSK_OFF_SEC, 0); chk(rd[7:0], 8'h80);
    seen = 0;
    // Stored and presented last key both all ones: must still fail.
    blank_keys <= 1;
    cmd(5, '{16'h0C00, 16'h1111, 16'h2222, 16'h3333, 16'hFFFF});
    blank_keys <= 0;
    chk(rd[5:0], 6'h33);
    chk(seen, 1);
    cmd(5, '{16'h0C00, 16'h1111, 16'h2222, 16'h3333, 16'h4444});
    chk(rd[5:4], 2'h3);
    do_reset;
    chk(rd[5:0], 6'h11);
    cmd(5, '{16'h0C00, 16'h1111, 16'h2222, 16'h3333, 16'h4444});
    chk(rd[5:0], 6'h01);
    $display("key test done");
  endtask
  // Blank and non-blank sections, interrupt, stop request, errors.
  task t_section;
    apb(1, `FSK_OFF_MASK, 3);
    apb(1, `FSK_OFF_IRQ, 3);
    cmd(3, '{16'h0300, 16'h0000, 16'h0001, 16'h0, 16'h0});
    chk(rd[3:1], 3'h0);
    chk(irq, 1);
    apb(1, `FSK_OFF_IRQ, 3);
    @(posedge pclk);
    chk(irq, 0);
    cmd(3, '{16'h0300, 16'h0100, 16'h0001, 16'h0, 16'h0});
    chk(rd[3:1], 3'h6);
    // Long blank section so the stop request meets a busy command.
    stop_req <= 1;
    apb(1, `FSK_OFF_CCOBIX, 1);
    apb(1, `FSK_OFF_CCOB, 0);
    apb(1, `FSK_OFF_CCOBIX, 2);
    apb(1, `FSK_OFF_CCOB, 8);
    apb(1, `FSK_OFF_CTRL, 1);
    @(posedge pclk); chk(stop_ack, 0);
    wait_done; chk(stop_ack, 1);
    chk(rd[3:1], 3'h0);
    stop_req <= 0;
    cmd(3, '{16'h0300, 16'h0102, 16'h0001, 16'h0, 16'h0});
    chk(rd[3:0], 4'h3);
    do_reset;
    cmd(2, '{16'h0300, 16'h0000, 16'h0, 16'h0, 16'h0});
    chk(rd[4:0], 5'h13);
    apb(0, 12'h020, 0); chk(slv, 1);
    $display("section test done");
  endtask
  initial begin
    do_reset;
    t_keys;
    t_section;
    end_sim;
  end
endmodule
bind fsk_ctrl fsk_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .mem_rd(mem_rd), .mem_addr(mem_addr), .stop_req(stop_req),
  .stop_ack(stop_ack), .read_invalid(read_invalid));
